//--- shared/emb_pkg.sv
package emb_pkg;

  localparam int ADDR_W = 20;
  localparam int AD_W   = 16;
  localparam int HI_W   = 4;
  localparam int CTL_W  = 8;

  // control port bit positions
  localparam int CTL_ALE = 0;
  localparam int CTL_OE  = 1;
  localparam int CTL_WRL = 2;
  localparam int CTL_WRH = 3;
  localparam int CTL_BA  = 4;
  localparam int CTL_CE  = 5;
  localparam int CTL_LB  = 6;
  localparam int CTL_UB  = 7;

  // idle control level: strobes inactive high, byte lane low
  localparam logic [7:0] CTL_IDLE = 8'hEF;

  // data width modes
  typedef enum logic {
    EMB_W8  = 1'b0,
    EMB_W16 = 1'b1
  } emb_width_t;

  // address width selection
  typedef enum logic [1:0] {
    EMB_A20 = 2'h0,
    EMB_A16 = 2'h1,
    EMB_A12 = 2'h2
  } emb_awidth_t;

  // bus cycle states, gray along the usual path except the DONE to IDLE step
  typedef enum logic [2:0] {
    EMB_IDLE  = 3'h0,
    EMB_ADDR  = 3'h1,
    EMB_LATCH = 3'h3,
    EMB_DATA  = 3'h2,
    EMB_DONE  = 3'h6
  } emb_state_t;

  // core request
  typedef struct packed {
    logic        fetch;
    logic        twrite;
    logic [19:0] ptr;
    logic [7:0]  latch;
  } emb_req_t;

  // pin bundle
  typedef struct packed {
    logic [15:0] ad_out;
    logic [15:0] ad_oe_n;
    logic [3:0]  a_hi;
    logic [7:0]  ctl;
  } emb_pins_t;

  // phase cycles within one instruction cycle (one phase per clock)
  localparam int PHASE_CNT_W = 2;

  // read data phase hold, long enough for pin data to clear the four-flop input path
  localparam int         DCNT_W    = 3;
  localparam logic [2:0] DATA_HOLD = 3'h4;

endpackage : emb_pkg

//--- verilog/emb_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage input synchroniser with agreement filter
module emb_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire  [WIDTH-1:0] agree = ~(s2 ^ s3);

  // shift chain, output updates only where stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= (agree & s3) | (~agree & dout);
    end
  end

endmodule : emb_sync
`default_nettype wire

//--- verilog/emb_addr_mux.sv
`timescale 1ns/1ps
`default_nettype none
// masks the upper address bits according to the selected address width
module emb_addr_mux (
  // selection
  input  wire logic                 [1:0]  awidth,
  // address
  input  wire logic                 [19:0] addr,
  output logic                      [19:0] addr_out
);

  // width mask decode
  function automatic logic [19:0] width_mask(input logic [1:0] w);
    case (w)
      emb_pkg::EMB_A16: width_mask = 20'h0FFFF;
      emb_pkg::EMB_A12: width_mask = 20'h00FFF;
      default:          width_mask = 20'hFFFFF;
    endcase
  endfunction

  // three widths, widest 20 bits
  assign addr_out = addr & width_mask(awidth);

endmodule : emb_addr_mux
`default_nettype wire

//--- verilog/emb_bus.sv
`timescale 1ns/1ps
`default_nettype none
// external memory bus master, 8-bit multiplexed mode with 16-bit pass-through
module emb_bus (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  // configuration
  input  wire emb_pkg::emb_width_t    width_mode,
  input  wire logic        [1:0]      addr_width,
  input  wire logic                   sleep,
  // core request
  input  wire emb_pkg::emb_req_t      req,
  output logic                        busy,
  output logic                        done,
  output logic             [15:0]     rd_word,
  // pins
  input  wire logic        [15:0]     ad_in,
  output emb_pkg::emb_pins_t          pins
);

  emb_pkg::emb_state_t state;
  emb_pkg::emb_state_t next_state;
  logic                second;      // second byte of the pair
  logic                is_wr;
  logic [19:0]         addr_q;
  logic [7:0]          wdata;
  logic [7:0]          lo_byte;
  logic [15:0]         ad_sync;
  logic [19:0]         addr_m;
  logic [emb_pkg::DCNT_W-1:0] dcnt;  // cycles spent in the data phase

  // pin data inputs synchronised
  emb_sync #(.WIDTH(16)) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (ad_in),
    .dout   (ad_sync)
  );

  // address width masking
  emb_addr_mux u_amux (
    .awidth   (addr_width),
    .addr     (req.ptr),
    .addr_out (addr_m)
  );

  // request decode
  wire start     = (state == emb_pkg::EMB_IDLE) && !sleep && (req.fetch || req.twrite);
  wire is_w8     = (width_mode == emb_pkg::EMB_W8);
  wire pair_next = is_w8 && !is_wr && !second;
  // reads hold the data phase until the synchronised byte is settled
  wire data_last = (state == emb_pkg::EMB_DATA) && (is_wr || dcnt == emb_pkg::DATA_HOLD);

  // next state
  always_comb begin
    next_state = state;
    case (state)
      emb_pkg::EMB_IDLE:  if (start) next_state = emb_pkg::EMB_ADDR;
      emb_pkg::EMB_ADDR:  next_state = emb_pkg::EMB_LATCH;
      emb_pkg::EMB_LATCH: next_state = emb_pkg::EMB_DATA;
      emb_pkg::EMB_DATA: begin
        if (data_last) next_state = pair_next ? emb_pkg::EMB_LATCH : emb_pkg::EMB_DONE;
      end
      emb_pkg::EMB_DONE:  next_state = emb_pkg::EMB_IDLE;
      default:            next_state = emb_pkg::EMB_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) state <= emb_pkg::EMB_IDLE;
    else         state <= next_state;
  end

  // data phase counter, cleared outside the data phase
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)                                       dcnt <= '0;
    else if (state == emb_pkg::EMB_DATA && !data_last) dcnt <= dcnt + 3'h1;
    else                                               dcnt <= '0;
  end

  // request capture, byte pointer and latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= '0;
      wdata  <= '0;
      is_wr  <= 1'b0;
      second <= 1'b0;
    end else if (start) begin
      addr_q <= addr_m;
      wdata  <= req.latch;
      is_wr  <= req.twrite;
      second <= 1'b0;
    end else if (data_last && pair_next) begin
      second <= 1'b1;            // byte lane toggles
    end
  end

  // read data assembly
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lo_byte <= '0;
      rd_word <= '0;
    end else if (data_last && !is_wr) begin
      if (!is_w8)       rd_word <= ad_sync;
      else if (!second) lo_byte <= ad_sync[7:0];
      else              rd_word <= {ad_sync[7:0], lo_byte};
    end
  end

  // handshake flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= (next_state != emb_pkg::EMB_IDLE);
      done <= (next_state == emb_pkg::EMB_DONE);
    end
  end

  // pin values for the coming state
  wire        nx_addr  = (next_state == emb_pkg::EMB_ADDR) || (next_state == emb_pkg::EMB_LATCH);
  wire        nx_data  = (next_state == emb_pkg::EMB_DATA);
  wire        nx_act   = (next_state != emb_pkg::EMB_IDLE) && (next_state != emb_pkg::EMB_DONE);
  wire        st_addr  = (state == emb_pkg::EMB_IDLE);
  wire [19:0] cur_addr = st_addr ? addr_m : addr_q;
  wire        cur_wr   = st_addr ? req.twrite : is_wr;
  wire        cur_sec  = data_last ? pair_next : second;
  wire [7:0]  cur_wd   = st_addr ? req.latch : wdata;
  wire        lane     = cur_wr ? cur_addr[0] : cur_sec;
  wire [15:0] nx_adout = nx_data ? {cur_wd, cur_wd} : cur_addr[15:0];
  wire        nx_drive = nx_addr || (nx_data && cur_wr);
  wire        nx_ale   = !(next_state == emb_pkg::EMB_ADDR);
  wire        nx_oe    = !(nx_data && !cur_wr);
  wire        nx_wrl   = !(nx_data && cur_wr);
  wire        nx_wrh   = !(nx_data && cur_wr && !is_w8);
  wire        nx_ce    = !(nx_act && !sleep);
  wire        nx_lb    = !(nx_act && (!is_w8 || !lane));
  wire        nx_ub    = !(nx_act && (!is_w8 || lane));

  // registered pin drivers, 28 pins total
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pins.ad_out  <= '0;
      pins.ad_oe_n <= '1;
      pins.a_hi    <= '0;
      pins.ctl     <= emb_pkg::CTL_IDLE;
    end else begin
      pins.ad_out  <= nx_adout;
      pins.ad_oe_n <= {emb_pkg::AD_W{!nx_drive}};
      pins.a_hi    <= cur_addr[19:16];
      pins.ctl[emb_pkg::CTL_ALE] <= nx_ale;
      pins.ctl[emb_pkg::CTL_OE]  <= nx_oe;
      pins.ctl[emb_pkg::CTL_WRL] <= nx_wrl;
      pins.ctl[emb_pkg::CTL_WRH] <= nx_wrh;
      pins.ctl[emb_pkg::CTL_BA]  <= lane;
      pins.ctl[emb_pkg::CTL_CE]  <= nx_ce;
      pins.ctl[emb_pkg::CTL_LB]  <= nx_lb;
      pins.ctl[emb_pkg::CTL_UB]  <= nx_ub;
    end
  end

  // assertions
  sequence s_fetch8;
    state == emb_pkg::EMB_ADDR && !is_wr && is_w8;
  endsequence

  a_two_byte_fetch: assert property (@(posedge clock) disable iff (!arst_n)
    s_fetch8 |-> ##13 (state == emb_pkg::EMB_DONE))
    else $error("8-bit fetch did not finish in two byte phases");

  a_ce_sleep: assert property (@(posedge clock) disable iff (!arst_n)
    $past(sleep) && sleep |-> pins.ctl[emb_pkg::CTL_CE])
    else $error("chip select active in sleep");

  a_ce_access: assert property (@(posedge clock) disable iff (!arst_n)
    !pins.ctl[emb_pkg::CTL_OE] || !pins.ctl[emb_pkg::CTL_WRL]
      |-> !pins.ctl[emb_pkg::CTL_CE])
    else $error("strobe without chip select");

  a_wr_both_halves: assert property (@(posedge clock) disable iff (!arst_n)
    !pins.ctl[emb_pkg::CTL_WRL] |-> pins.ad_out[15:8] == pins.ad_out[7:0]
      && pins.ad_oe_n == 16'h0000)
    else $error("write byte not on both halves");

  a_wr_lane: assert property (@(posedge clock) disable iff (!arst_n)
    !pins.ctl[emb_pkg::CTL_WRL] |-> pins.ctl[emb_pkg::CTL_BA] == addr_q[0])
    else $error("byte lane differs from pointer lsb");

  a_ale_addr: assert property (@(posedge clock) disable iff (!arst_n)
    !pins.ctl[emb_pkg::CTL_ALE] |-> pins.ad_oe_n == 16'h0000
      && pins.ctl[emb_pkg::CTL_OE])
    else $error("latch strobe without driven address");

  a_lane_toggle: assert property (@(posedge clock) disable iff (!arst_n)
    s_fetch8 |-> ##2 !pins.ctl[emb_pkg::CTL_BA] ##6 pins.ctl[emb_pkg::CTL_BA])
    else $error("byte lane did not toggle between bytes");

  a_w8_no_wrh: assert property (@(posedge clock) disable iff (!arst_n)
    is_w8 |-> pins.ctl[emb_pkg::CTL_WRH])
    else $error("high write strobe in 8-bit mode");

endmodule : emb_bus
`default_nettype wire

//--- sim/emb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// byte-wide memory behind an external address latch
module emb_mem_model (
  // clock
  input  wire logic               clock,
  // pins of the bus master
  input  wire emb_pkg::emb_pins_t pins,
  // read data and latched address
  output logic             [15:0] ad_in,
  output logic             [19:0] held_addr
);
  logic [7:0] mem [0:255];
  logic [7:0] rd_byte;
  logic [1:0] hold;
  logic       ale_q;
  wire        drive = !pins.ctl[1] && !pins.ctl[5];
  wire  [7:0] idx   = {held_addr[7:1], pins.ctl[4]};
  // fill with a known pattern
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    held_addr = '0;
    rd_byte = '0;
    hold = '0;
    ale_q = 1'b1;
  end
  // address latch, byte writes and read data hold
  always @(posedge clock) begin
    ale_q <= pins.ctl[0];
    if (!ale_q && pins.ctl[0]) held_addr <= {pins.a_hi, pins.ad_out};
    if (!pins.ctl[2] && !pins.ctl[5]) mem[idx] <= pins.ad_out[7:0];
    if (drive) begin
      rd_byte <= mem[idx];
      hold <= 2'h3;
    end else if (hold != 0) hold <= hold - 2'h1;
  end
  // released low lines hold the last byte for three cycles, then show its inverse; high lines always show the inverse
  assign ad_in[7:0]  = drive ? mem[idx] : (hold != 0 ? rd_byte : ~rd_byte);
  assign ad_in[15:8] = ~rd_byte;
endmodule // emb_mem_model
`default_nettype wire

//--- sim/emb_bus_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
// self-checking bench for the bus master
module emb_bus_test;
  typedef struct packed {
    logic        w;
    logic [1:0]  aw;
    logic [19:0] ptr;
    logic [7:0]  b;
    logic [15:0] word;
  } emb_row_t;
  logic                clock;
  logic                arst_n;
  logic                sleep;
  logic [1:0]          addr_width;
  emb_pkg::emb_width_t width_mode;
  emb_pkg::emb_req_t   req;
  emb_pkg::emb_pins_t  pins;
  logic                busy;
  logic                done;
  logic [15:0]         rd_word;
  logic [15:0]         ad_in;
  logic [19:0]         held_addr;
  emb_row_t            rows [0:4];
  int                  bad_count;
  int                  compares;
  int                  cycles;
  emb_bus i_dut (.clock(clock), .arst_n(arst_n), .width_mode(width_mode),
    .addr_width(addr_width), .sleep(sleep), .req(req), .busy(busy), .done(done),
    .rd_word(rd_word), .ad_in(ad_in), .pins(pins));
  emb_mem_model i_mem (.clock(clock), .pins(pins), .ad_in(ad_in), .held_addr(held_addr));
  // clock and hang limit
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one access from a table row, checked cycle by cycle
  task automatic run_op(input int r);
    int n;
    logic [19:0] ea;
    ea = rows[r].ptr & (rows[r].aw == 0 ? 20'hFFFFF : rows[r].aw == 1 ? 20'h0FFFF : 20'h00FFF);
    @(posedge clock) req <= '{fetch: !rows[r].w, twrite: rows[r].w, ptr: rows[r].ptr, latch: rows[r].b};
    addr_width <= rows[r].aw;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
      if (busy === 1'b1) req <= '0;
      if (pins.ctl[0] === 1'b0) `CHK("cs at latch", 1'b0, pins.ctl[5])
      if (pins.ctl[1] === 1'b0) `CHK("bus released", 8'hFF, pins.ad_oe_n[7:0])
      if (pins.ctl[2] === 1'b0) begin
        `CHK("write data", {2{rows[r].b}}, pins.ad_out)
        `CHK("write lane", rows[r].ptr[0], pins.ctl[4])
      end
    end while (done !== 1'b1 && n < 20);
    `CHK("done latency", rows[r].w ? 4 : 14, n)
    `CHK("latched addr", ea[19:1], held_addr[19:1])
    if (!rows[r].w) `CHK("read word", rows[r].word, rd_word)
    @(posedge clock);
    #1;
    `CHK("done pulse", 1'b0, done)
    $display("row %0d done", r);
  endtask
  // reset, table rows, then sleep
  initial begin
    clock = 0;
    arst_n = 0;
    sleep = 0;
    addr_width = 0;
    req = '0;
    width_mode = emb_pkg::EMB_W8;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    rows[0] = '{1'b1, 2'h0, 20'h12344, 8'h5A, 16'h0000};
    rows[1] = '{1'b1, 2'h0, 20'h12345, 8'h3C, 16'h0000};
    rows[2] = '{1'b0, 2'h0, 20'h12344, 8'h00, 16'h3C5A};
    rows[3] = '{1'b0, 2'h1, 20'hFABC6, 8'h00, 16'h6263};
    rows[4] = '{1'b0, 2'h2, 20'hFFF10, 8'h00, 16'hB4B5};
    repeat (3) @(posedge clock);
    #1;
    `CHK("idle ctl", emb_pkg::CTL_IDLE, pins.ctl)
    `CHK("idle drive", 16'hFFFF, pins.ad_oe_n)
    @(posedge clock) arst_n <= 1'b1;
    $display("reset test done");
    for (int r = 0; r < 5; r++) run_op(r);
    // byte write once more in 16-bit mode
    @(posedge clock) width_mode <= emb_pkg::EMB_W16;
    run_op(0);
    @(posedge clock) width_mode <= emb_pkg::EMB_W8;
    @(posedge clock) sleep <= 1'b1;
    req <= '{fetch: 1'b1, twrite: 1'b0, ptr: 20'h00010, latch: 8'h00};
    repeat (8) @(posedge clock);
    #1;
    `CHK("sleep busy", 1'b0, busy)
    `CHK("sleep cs", 1'b1, pins.ctl[5])
    @(posedge clock) req <= '0;
    sleep <= 1'b0;
    $display("sleep test done");
    report_and_stop();
  end
endmodule // emb_bus_test
`default_nettype wire
